//--- logic/mfw_flow_watchdog.sv
// What this block does
// R1 - early receive threshold code selects eighths
// R2 - near overflow at 32 bytes per code
// R3 - mode bit: either or both enables
// R4 - zero-pause command sends pause time 0000h
// R5 - full-pause command sends FFFFh, self-clears
// R6 - no descriptor sends a pause frame
// R7 - fifo level sends FFFFh, empty sends 0000h
// R8 - decode pause frames, latch read-clear status
// R9 - watchdog release after 44 or 20 bits
// R10 - disable bit stops the receive watchdog
// R11 - code 32h selects transmit fifo port
// R12 - code 35h selects receive fifo port
// R13 - code 38h resets pointers, write-only
// R14 - early receive event at selected fill
// R15 - defer transmit for received pause quanta
module mfw_flow_watchdog
  import mfw_pkg::*;
#(
  parameter int WDOG_BITS = 16384
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // receive path status
  input  wire logic [RX_LVL_W-1:0] rx_fifo_level,
  input  wire logic                rx_desc_unavail,
  input  wire logic                rx_active,
  input  wire mfw_pause_t          rx_pause,
  output logic                     rx_channel_en,
  output logic                     early_rx_event,
  output logic                     rx_near_overflow,
  // pause transmit request
  output logic                     pause_tx_req,
  output logic [15:0]              pause_tx_time,
  input  wire logic                pause_tx_done,
  output logic                     tx_defer,
  // diagnostic fifo port
  output logic                     tx_buffer_port,
  output logic                     rx_buffer_port,
  output logic                     diag_pointer_reset,
  output logic                     diag_wr,
  output logic                     diag_rd,
  output logic [31:0]              diag_wdata,
  input  wire logic [31:0]         diag_rdata,
  // interrupt
  output logic                     irq
);

  localparam int          WDOG_W        = $clog2(WDOG_BITS + 1);
  localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_BITS - 1);
  localparam logic [5:0]  REL_LONG_LAST  = 6'(REL_LONG_BITS - 1);
  localparam logic [5:0]  REL_SHORT_LAST = 6'(REL_SHORT_BITS - 1);
  localparam logic [1:0]  BIT_DIV_LAST   = 2'(BIT_CYCLES - 1);

  logic [31:0]        flow_reg;
  logic [5:0]         dsel_reg;
  logic [IRQ_W-1:0]   stat_reg;
  logic [IRQ_W-1:0]   mask_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;
  logic               irq_reg;
  logic [1:0]         div_reg;
  logic               bit_tick;
  logic               early_reg;
  logic               early_evt_reg;
  logic               near_reg;
  logic               xoff_sent_reg;
  logic               pend_full_reg;
  logic               pend_zero_reg;
  logic               req_full_reg;
  mfw_pause_state_t   pstate;
  logic               preq_reg;
  logic [15:0]        ptime_reg;
  logic               ptx_done_evt;
  logic [WDOG_W-1:0]  wdog_reg;
  logic [5:0]         rel_reg;
  logic               chan_en_reg;
  logic               wdog_evt;
  logic               dptr_rst_reg;
  logic               dwr_reg;
  logic               drd_reg;
  logic [31:0]        dwdata_reg;
  logic               pause_active;

  // apb decode; one wait state so every answer comes from a flop
  wire access   = psel && penable && !pready_reg;
  wire done     = psel && penable && pready_reg;
  wire wr_done  = done && pwrite;
  wire rd_done  = done && !pwrite;
  wire hit_dsel = (paddr == DIAG_SEL_OFS);
  wire hit_flow = (paddr == FLOW_CTRL_OFS);
  wire hit_stat = (paddr == IRQ_STAT_OFS);
  wire hit_mask = (paddr == IRQ_MASK_OFS);
  wire hit_data = (paddr == DIAG_DATA_OFS);
  wire hit_lvl  = (paddr == RX_LEVEL_OFS);
  wire mapped   = hit_dsel | hit_flow | hit_stat | hit_mask | hit_data | hit_lvl;

  // control fields
  wire [2:0] erx_code  = flow_reg[ERT_HI:ERT_LO];
  wire [5:0] ovf_code  = flow_reg[OVT_HI:OVT_LO];
  wire       mode_both = flow_reg[PCM_BIT];
  wire       en_desc   = flow_reg[PND_BIT];
  wire       en_fifo   = flow_reg[PFL_BIT];
  wire       fc_en     = flow_reg[FCE_BIT];
  wire       rel_long  = flow_reg[GRI_BIT];
  wire       wdog_off  = flow_reg[GRD_BIT];

  wire dsel_tx = (dsel_reg == DSEL_TX);
  wire dsel_rx = (dsel_reg == DSEL_RX);

  // fill thresholds
  wire [RX_LVL_W-1:0] erx_thresh = RX_LVL_W'(erx_code) << ERX_STEP_SHIFT;
  wire [RX_LVL_W-1:0] ovf_thresh = RX_LVL_W'(ovf_code) << OVF_UNIT_SHIFT;
  wire early_now = (erx_code != 3'b000) && (rx_fifo_level >= erx_thresh); // R1 R14
  wire near_now  = fc_en && (ovf_code != 6'h00) && (rx_fifo_level >= ovf_thresh); // R2
  wire rx_empty  = (rx_fifo_level == '0);

  // automatic pause gating
  wire allow_desc = mode_both ? (en_desc && en_fifo) : en_desc; // R3
  wire allow_fifo = mode_both ? (en_desc && en_fifo) : en_fifo; // R3
  wire desc_evt   = rx_desc_unavail && allow_desc; // R6
  wire xoff_evt   = near_now && !near_reg && allow_fifo; // R7
  wire xon_evt    = rx_empty && xoff_sent_reg && allow_fifo; // R7
  wire zero_cmd   = wr_done && hit_flow && pwdata[SZP_BIT]; // R4
  wire pause_rx   = rx_pause.valid && fc_en; // R8

  // watchdog
  wire wdog_run     = !wdog_off && chan_en_reg && rx_active; // R10
  wire wdog_expire  = wdog_run && bit_tick && (wdog_reg == WDOG_LAST);
  wire [5:0] rel_last = rel_long ? REL_LONG_LAST : REL_SHORT_LAST; // R9
  wire rel_done     = !chan_en_reg && bit_tick && (rel_reg == rel_last);

  // flow register read image
  wire [31:0] flow_rd = {flow_reg[31:8], pause_active, flow_reg[6:0]} & 32'h01FF_FEF0;

  wire [31:0] rd_mux =
      hit_dsel ? {23'h000000, dsel_reg, 3'b000} :
      hit_flow ? {flow_rd[31:PDC_BIT+1], pause_active, flow_rd[PDC_BIT-1:0]} :
      hit_stat ? {27'h0000000, stat_reg} :
      hit_mask ? {27'h0000000, mask_reg} :
      hit_data ? ((dsel_tx || dsel_rx) ? diag_rdata : 32'h0000_0000) :
      hit_lvl  ? {20'h00000, rx_fifo_level} : 32'h0000_0000;

  // sticky events, set wins over write-one-clear
  wire [IRQ_W-1:0] evt_vec;
  assign evt_vec[IRQ_EARLY_RX] = early_evt_reg;
  assign evt_vec[IRQ_NEAR_OVF] = near_now && !near_reg;
  assign evt_vec[IRQ_PAUSE_RX] = pause_rx;
  assign evt_vec[IRQ_WDOG]     = wdog_evt;
  assign evt_vec[IRQ_PAUSE_TX] = ptx_done_evt;
  wire [IRQ_W-1:0] stat_clr = (wr_done && hit_stat) ? pwdata[IRQ_W-1:0] : '0;

  assign ptx_done_evt = (pstate == PS_SEND) && pause_tx_done;

  // apb answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access && !mapped;
      prdata_reg  <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // flow_watchdog_control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_reg <= FLOW_CTRL_RST;
    end else begin
      if (wr_done && hit_flow) begin
        flow_reg[31:10] <= pwdata[31:10];
        flow_reg[6:4]   <= pwdata[6:4];
      end else if (ptx_done_evt && req_full_reg) begin
        flow_reg[SFP_BIT] <= 1'b0; // R5
      end
      if (pause_rx) begin
        flow_reg[PDL_BIT] <= 1'b1; // R8
      end else if (rd_done && hit_flow) begin
        flow_reg[PDL_BIT] <= 1'b0; // R8
      end
    end
  end

  // diagnostic select and strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsel_reg     <= 6'h00;
      dptr_rst_reg <= 1'b0;
      dwr_reg      <= 1'b0;
      drd_reg      <= 1'b0;
      dwdata_reg   <= 32'h0000_0000;
    end else begin
      dptr_rst_reg <= wr_done && hit_dsel && (pwdata[DSEL_HI:DSEL_LO] == DSEL_RESET); // R13
      // reset code is not kept, so it never reads back
      if (wr_done && hit_dsel && (pwdata[DSEL_HI:DSEL_LO] != DSEL_RESET)) begin
        dsel_reg <= pwdata[DSEL_HI:DSEL_LO]; // R11 R12
      end
      dwr_reg    <= wr_done && hit_data && (dsel_tx || dsel_rx); // R11 R12
      drd_reg    <= rd_done && hit_data && (dsel_tx || dsel_rx); // R11 R12
      dwdata_reg <= pwdata;
    end
  end

  // interrupts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | evt_vec;
      if (wr_done && hit_mask) begin
        mask_reg <= pwdata[IRQ_W-1:0];
      end
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  // bit-time enable from the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 2'b00;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= (div_reg == BIT_DIV_LAST);
      div_reg  <= (div_reg == BIT_DIV_LAST) ? 2'b00 : div_reg + 2'b01;
    end
  end

  // fill level events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_reg     <= 1'b0;
      early_evt_reg <= 1'b0;
      near_reg      <= 1'b0;
    end else begin
      early_reg     <= early_now;
      early_evt_reg <= early_now && !early_reg; // R14
      near_reg      <= near_now; // R2
    end
  end

  // pause frame requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_full_reg <= 1'b0;
      pend_zero_reg <= 1'b0;
      xoff_sent_reg <= 1'b0;
      req_full_reg  <= 1'b0;
      preq_reg      <= 1'b0;
      ptime_reg     <= PAUSE_ZERO;
      pstate        <= PS_IDLE;
    end else begin
      if (desc_evt || xoff_evt) begin
        pend_full_reg <= 1'b1; // R6 R7
      end else if (ptx_done_evt && req_full_reg) begin
        pend_full_reg <= 1'b0;
      end
      if (zero_cmd || xon_evt) begin
        pend_zero_reg <= 1'b1; // R4 R7
      end else if (ptx_done_evt && !req_full_reg) begin
        pend_zero_reg <= 1'b0;
      end
      if (xoff_evt) begin
        xoff_sent_reg <= 1'b1;
      end else if (xon_evt || !allow_fifo) begin
        xoff_sent_reg <= 1'b0;
      end
      case (pstate)
        PS_IDLE: begin
          if (pend_full_reg || flow_reg[SFP_BIT]) begin
            req_full_reg <= 1'b1;
            ptime_reg    <= PAUSE_FULL; // R5 R6 R7
            preq_reg     <= 1'b1;
            pstate       <= PS_SEND;
          end else if (pend_zero_reg) begin
            req_full_reg <= 1'b0;
            ptime_reg    <= PAUSE_ZERO; // R4 R7
            preq_reg     <= 1'b1;
            pstate       <= PS_SEND;
          end
        end
        PS_SEND: begin
          if (pause_tx_done) begin
            preq_reg <= 1'b0;
            pstate   <= PS_IDLE;
          end
        end
        default: begin
          preq_reg <= 1'b0;
          pstate   <= PS_IDLE;
        end
      endcase
    end
  end

  // receive watchdog and release interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_reg    <= '0;
      rel_reg     <= 6'h00;
      chan_en_reg <= 1'b1;
      wdog_evt    <= 1'b0;
    end else begin
      wdog_evt <= wdog_expire;
      if (!wdog_run) begin
        wdog_reg <= '0; // R10
      end else if (bit_tick) begin
        wdog_reg <= wdog_reg + WDOG_W'(1);
      end
      if (wdog_expire) begin
        chan_en_reg <= 1'b0;
        rel_reg     <= 6'h00;
      end else if (rel_done) begin
        chan_en_reg <= 1'b1; // R9
      end else if (!chan_en_reg && bit_tick) begin
        rel_reg <= rel_reg + 6'h01;
      end
    end
  end

  mfw_pause_timer u_pause_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .bit_tick (bit_tick),
    .load     (pause_rx), // R15
    .quanta   (rx_pause.quanta),
    .active   (pause_active)
  );

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign rx_channel_en      = chan_en_reg;
  assign early_rx_event     = early_evt_reg;
  assign rx_near_overflow   = near_reg;
  assign pause_tx_req       = preq_reg;
  assign pause_tx_time      = ptime_reg;
  assign tx_defer           = pause_active;
  assign tx_buffer_port     = dsel_tx;
  assign rx_buffer_port     = dsel_rx;
  assign diag_pointer_reset = dptr_rst_reg;
  assign diag_wr            = dwr_reg;
  assign diag_rd            = drd_reg;
  assign diag_wdata         = dwdata_reg;
  assign irq                = irq_reg;

  a_early_off: assert property (@(posedge pclk) disable iff (!presetn)
    erx_code == 3'b000 && $past(erx_code) == 3'b000 |-> !early_evt_reg) // R1
    else $error("early receive event with threshold disabled");

  a_near_level: assert property (@(posedge pclk) disable iff (!presetn)
    near_now |=> rx_near_overflow) // R2
    else $error("near overflow not flagged at threshold");

  a_mode_both: assert property (@(posedge pclk) disable iff (!presetn)
    mode_both && !(en_desc && en_fifo) |-> !desc_evt && !xoff_evt) // R3
    else $error("pause sent with only one enable in both mode");

  a_zero_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pause_tx_req) && !req_full_reg |-> pause_tx_time == 16'h0000) // R4
    else $error("zero pause frame carries wrong time");

  a_full_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ptx_done_evt && req_full_reg && !(wr_done && hit_flow) |=> !flow_reg[SFP_BIT]) // R5
    else $error("full pause bit not cleared after send");

  a_desc_pause: assert property (@(posedge pclk) disable iff (!presetn)
    desc_evt && pstate == PS_IDLE |-> ##[1:2] pause_tx_req && pause_tx_time == 16'hFFFF) // R6
    else $error("no pause frame for missing descriptor");

  a_decode_latch: assert property (@(posedge pclk) disable iff (!presetn)
    pause_rx |=> flow_reg[PDL_BIT] && tx_defer == ($past(rx_pause.quanta) != 16'h0000)) // R8
    else $error("pause decode not latched");

  a_release_time: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(rx_channel_en) && !rel_long |-> !rx_channel_en [*8] ##[30:40] rx_channel_en) // R9
    else $error("short release interval out of range");

  a_guard_off: assert property (@(posedge pclk) disable iff (!presetn)
    wdog_off |=> wdog_reg == '0) // R10
    else $error("watchdog ran while disabled");

  a_diag_reset: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && hit_dsel && pwdata[DSEL_HI:DSEL_LO] == DSEL_RESET
      |=> diag_pointer_reset && $stable(dsel_reg)) // R13
    else $error("diag reset code mishandled");

endmodule : mfw_flow_watchdog

//--- logic/mfw_pkg.sv
package mfw_pkg;

  // apb register byte offsets
  localparam logic [7:0] DIAG_SEL_OFS   = 8'h00;
  localparam logic [7:0] FLOW_CTRL_OFS  = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h0C;
  localparam logic [7:0] DIAG_DATA_OFS  = 8'h10;
  localparam logic [7:0] RX_LEVEL_OFS   = 8'h14;

  // flow_watchdog_control fields
  localparam int ERT_HI   = 24;
  localparam int ERT_LO   = 22;
  localparam int OVT_HI   = 21;
  localparam int OVT_LO   = 16;
  localparam int PCM_BIT  = 15;
  localparam int SZP_BIT  = 14;
  localparam int SFP_BIT  = 13;
  localparam int PND_BIT  = 12;
  localparam int PFL_BIT  = 11;
  localparam int FCE_BIT  = 10;
  localparam int PDL_BIT  = 9;
  localparam int PDC_BIT  = 7;
  localparam int VLAN_BIT = 6;
  localparam int GRI_BIT  = 5;
  localparam int GRD_BIT  = 4;
  localparam logic [31:0] FLOW_CTRL_RST = 32'h0000_0000;

  // diag_fifo_access_select field and codes
  localparam int DSEL_HI = 8;
  localparam int DSEL_LO = 3;
  localparam logic [5:0] DSEL_TX    = 6'h32;
  localparam logic [5:0] DSEL_RX    = 6'h35;
  localparam logic [5:0] DSEL_RESET = 6'h38;

  // interrupt status bits
  localparam int IRQ_W        = 5;
  localparam int IRQ_EARLY_RX = 0;
  localparam int IRQ_NEAR_OVF = 1;
  localparam int IRQ_PAUSE_RX = 2;
  localparam int IRQ_WDOG     = 3;
  localparam int IRQ_PAUSE_TX = 4;

  // receive fifo geometry
  localparam int RX_LVL_W       = 12;
  localparam int RX_FIFO_BYTES  = 2048;
  localparam int ERX_STEP_SHIFT = $clog2(RX_FIFO_BYTES / 8);
  localparam int OVF_UNIT_SHIFT = 5;

  // pause values
  localparam logic [15:0] PAUSE_FULL = 16'hFFFF;
  localparam logic [15:0] PAUSE_ZERO = 16'h0000;
  localparam int QUANTUM_BITS = 512;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_TIME_NS   = 10;
  localparam int BIT_CYCLES    = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_LONG_BITS  = 44;
  localparam int REL_SHORT_BITS = 20;

  typedef struct packed {
    logic        valid;
    logic [15:0] quanta;
  } mfw_pause_t;

  typedef enum {PS_IDLE, PS_SEND} mfw_pause_state_t;

endpackage : mfw_pkg

//--- logic/mfw_pause_timer.sv
module mfw_pause_timer
  import mfw_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bit rate
  input  wire logic        bit_tick,
  // load from a decoded pause frame
  input  wire logic        load,
  input  wire logic [15:0] quanta,
  // defer state
  output logic             active
);

  localparam logic [8:0] BIT_LAST = 9'(QUANTUM_BITS - 1);

  logic [15:0] quanta_reg;
  logic [8:0]  bit_reg;
  logic        active_reg;

  wire quantum_end = bit_tick && (bit_reg == BIT_LAST);
  wire last_quanta = (quanta_reg == 16'h0001);

  // a new frame restarts the wait; zero quanta cancels it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quanta_reg <= 16'h0000;
      bit_reg    <= 9'h000;
      active_reg <= 1'b0;
    end else if (load) begin // R15
      quanta_reg <= quanta;
      bit_reg    <= 9'h000;
      active_reg <= (quanta != 16'h0000);
    end else if (active_reg && bit_tick) begin // R15
      bit_reg <= bit_reg + 9'h001;
      if (quantum_end) begin
        quanta_reg <= quanta_reg - 16'h0001;
        active_reg <= !last_quanta;
      end
    end
  end

  assign active = active_reg;

  a_zero_cancels: assert property (@(posedge pclk) disable iff (!presetn)
    load && quanta == 16'h0000 |=> !active) // R15
    else $error("zero pause did not end deferral");

endmodule : mfw_pause_timer

//--- tb/mfw_station.sv
module mfw_station
  import mfw_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // pause frames sent by the device
  input  wire logic        pause_tx_req,
  input  wire logic [15:0] pause_tx_time,
  output logic             pause_tx_done,
  // pause frames sent to the device
  input  wire logic        tx_frame,
  input  wire logic [15:0] tx_quanta,
  output mfw_pause_t       rx_pause,
  // pacing and record
  input  wire logic [7:0]  lag,
  output logic [7:0]       sent,
  output logic [15:0]      last
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_tx_done <= 1'b0;
      rx_pause      <= '0;
      cnt_reg       <= 8'h00;
      sent          <= 8'h00;
      last          <= 16'h0000;
    end else begin
      pause_tx_done  <= 1'b0;
      rx_pause.valid <= tx_frame;
      // idle quanta toggles so a stale value is never mistaken for a frame
      rx_pause.quanta <= tx_frame ? tx_quanta : ~rx_pause.quanta;
      if (pause_tx_req && !pause_tx_done) begin
        if (cnt_reg == lag) begin
          pause_tx_done <= 1'b1;
          cnt_reg       <= 8'h00;
          sent          <= sent + 8'h01;
          last          <= pause_tx_time;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end
endmodule : mfw_station

//--- tb/test_mfw_flow_watchdog.sv
module test_mfw_flow_watchdog
  import mfw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, lag = 8'h0A, sent;
  logic [31:0] pwdata = 32'h0, prdata, diag_wdata, rd, diag_rdata = 32'hA5A5_0001;
  logic [RX_LVL_W-1:0] rx_fifo_level = 12'h000;
  logic rx_desc_unavail = 1'b0, rx_active = 1'b0, tx_frame = 1'b0, er;
  logic [15:0] q = 16'h0000, pause_tx_time, last;
  mfw_pause_t rx_pause;
  logic pready, pslverr, rx_channel_en, early_rx_event, rx_near_overflow, pause_tx_req;
  logic pause_tx_done, tx_defer, tx_buffer_port, rx_buffer_port, diag_pointer_reset;
  logic diag_wr, diag_rd, irq;
  int bad_count = 0, samples_checked = 0, rst_seen = 0;
  logic [31:0] r3 [3] = '{32'h0000_1000, 32'h0000_9000, 32'h0000_9800};

  mfw_flow_watchdog #(.WDOG_BITS(32)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_fifo_level, .rx_desc_unavail,
    .rx_active, .rx_pause, .rx_channel_en, .early_rx_event, .rx_near_overflow,
    .pause_tx_req, .pause_tx_time, .pause_tx_done, .tx_defer, .tx_buffer_port,
    .rx_buffer_port, .diag_pointer_reset, .diag_wr, .diag_rd, .diag_wdata,
    .diag_rdata, .irq);
  mfw_station u_station (.pclk, .presetn, .pause_tx_req, .pause_tx_time, .pause_tx_done,
    .tx_frame, .tx_quanta(q), .rx_pause, .lag, .sent, .last);

  always #2.5 pclk = ~pclk;
  always @(negedge pclk) if (diag_pointer_reset === 1'b1) rst_seen++;

  task summarize;
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // every wait is bounded; running out ends the run as a failure
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // pready is looked at on the rising edge where the slave samples the request
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xf

  task wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  function automatic logic sig(input int k);
    case (k)
      0: return pause_tx_req;
      1: return rx_channel_en;
      2: return tx_defer;
      default: return irq;
    endcase
  endfunction : sig

  task ws(input int k, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (sig(k) !== v && n < lim);
    if (n >= lim) begin
      bad_count++;
      summarize();
    end
  endtask : ws

  task lv(input int v);
    @(posedge pclk);
    rx_fifo_level <= v[RX_LVL_W-1:0];
    repeat (8) @(negedge pclk);
  endtask : lv

  task frame(input logic [15:0] v);
    @(posedge pclk);
    q <= v;
    tx_frame <= 1'b1;
    @(posedge pclk);
    tx_frame <= 1'b0;
  endtask : frame

  initial begin
    int n, c, s;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(rx_channel_en, 32'h1);
    rdc(FLOW_CTRL_OFS, 32'h0);
    rdc(DIAG_SEL_OFS, 32'h0);
    xf(1'b0, 8'h20, 32'h0);
    chk(er, 32'h1);
    wr(FLOW_CTRL_OFS, 32'h0000_2000);
    ws(0, 1'b1, 10, n);
    chk(pause_tx_time, 32'hFFFF);
    ws(0, 1'b0, 40, n);
    rdc(FLOW_CTRL_OFS, 32'h0);
    wr(FLOW_CTRL_OFS, 32'h0000_4000);
    ws(0, 1'b1, 10, n);
    ws(0, 1'b0, 40, n);
    chk(last, 32'h0);
    rdc(FLOW_CTRL_OFS, 32'h0000_4000);
    rdc(IRQ_STAT_OFS, 32'h10);
    chk(irq, 32'h0);
    wr(IRQ_MASK_OFS, 32'h10);
    ws(3, 1'b1, 5, n);
    wr(IRQ_STAT_OFS, 32'h10);
    ws(3, 1'b0, 5, n);
    for (c = 0; c < 3; c++) begin
      wr(FLOW_CTRL_OFS, r3[c]);
      s = sent;
      @(posedge pclk);
      rx_desc_unavail <= 1'b1;
      @(posedge pclk);
      rx_desc_unavail <= 1'b0;
      repeat (30) @(negedge pclk);
      chk(32'(sent) - s, 32'(c != 1));
    end
    wr(FLOW_CTRL_OFS, 32'h0002_0C00);
    lag <= 8'h00;
    wr(IRQ_STAT_OFS, 32'h1F);
    s = sent;
    lv(63);
    chk(rx_near_overflow, 32'h0);
    lv(64);
    chk(rx_near_overflow, 32'h1);
    chk({sent - s[7:0], last}, {8'h01, 16'hFFFF});
    lv(0);
    chk({sent - s[7:0], last}, {8'h02, 16'h0000});
    rdc(IRQ_STAT_OFS, 32'h12);
    for (c = 1; c < 8; c++) begin
      wr(FLOW_CTRL_OFS, 32'(c) << 22);
      lv(c * 256 - 1);
      wr(IRQ_STAT_OFS, 32'h1F);
      rdc(IRQ_STAT_OFS, 32'h0);
      lv(c * 256);
      rdc(IRQ_STAT_OFS, 32'h1);
    end
    wr(FLOW_CTRL_OFS, 32'h0);
    lv(0);
    wr(IRQ_STAT_OFS, 32'h1F);
    lv(2047);
    rdc(IRQ_STAT_OFS, 32'h0);
    lv(0);
    wr(FLOW_CTRL_OFS, 32'h0000_0400);
    frame(16'h0001);
    ws(2, 1'b1, 5, n);
    ws(2, 1'b0, 1100, n);
    chk(32'(n >= 1018 && n <= 1030), 32'h1);
    rdc(FLOW_CTRL_OFS, 32'h0000_0600);
    rdc(FLOW_CTRL_OFS, 32'h0000_0400);
    wr(FLOW_CTRL_OFS, 32'h0);
    frame(16'h0001);
    repeat (4) @(negedge pclk);
    chk(tx_defer, 32'h0);
    rdc(FLOW_CTRL_OFS, 32'h0);
    for (c = 0; c < 2; c++) begin
      wr(FLOW_CTRL_OFS, c ? 32'h20 : 32'h0);
      rx_active <= 1'b1;
      ws(1, 1'b0, 100, n);
      ws(1, 1'b1, 200, n);
      chk(32'(c ? (n >= 80 && n <= 96) : (n >= 32 && n <= 48)), 32'h1);
      @(posedge pclk);
      rx_active <= 1'b0;
    end
    wr(FLOW_CTRL_OFS, 32'h10);
    rx_active <= 1'b1;
    repeat (150) @(negedge pclk);
    chk(rx_channel_en, 32'h1);
    @(posedge pclk);
    rx_active <= 1'b0;
    wr(DIAG_SEL_OFS, 32'h190);
    rdc(DIAG_DATA_OFS, 32'hA5A5_0001);
    chk({tx_buffer_port, rx_buffer_port}, 32'h2);
    wr(DIAG_SEL_OFS, 32'h1A8);
    rdc(DIAG_SEL_OFS, 32'h1A8);
    chk({tx_buffer_port, rx_buffer_port}, 32'h1);
    s = rst_seen;
    wr(DIAG_SEL_OFS, 32'h1C0);
    rdc(DIAG_SEL_OFS, 32'h1A8);
    chk(rst_seen - s, 32'h1);
    summarize();
  end
endmodule : test_mfw_flow_watchdog
